// ==== inc/fifo_status_map.svh ====
// register indices, field positions and reset values of the buffer status block
`ifndef FIFO_STATUS_MAP_SVH
`define FIFO_STATUS_MAP_SVH

// register indices; byte address is four times the index
`define IDX_WTM_LO      8'h07
`define IDX_WTM_HI      8'h08
`define IDX_RATE        8'h09
`define IDX_MODE_CTRL   8'h0A
`define IDX_BCNT_HI     8'h0B
`define IDX_BCNT_LO     8'h0C
`define IDX_IRQ1_ROUTE  8'h0D
`define IDX_IRQ2_ROUTE  8'h0E
`define IDX_BDU_CTRL    8'h12
`define IDX_STATUS_LO   8'h3A
`define IDX_STATUS_HI   8'h3B
`define IDX_TAG         8'h78
`define IDX_OUT_XL      8'h79
`define IDX_OUT_ZH      8'h7E

// field positions
`define MODE_FLD        2:0
`define TRATE_FLD       5:4
`define TDEC_FLD        7:6
`define BCNT_CLR_BIT    6
`define BCNT_TH_HI_FLD  2:0
`define BDU_BIT         6
`define ROUTE_FLD       6:3
`define RATE_FLD        3:0

// reset values
`define RST_CTRL        8'h00
`define RST_THRESH      11'h000

// codes
`define TRATE_ON        2'h3
`define TDEC_OFF        2'h0
`define TDEC_DIV1       2'h1
`define TDEC_DIV8       2'h2
`define RATE_OFF        4'h0
`define TS_ZH_RATE_FLD  3:0

`endif

// ==== inc/fifo_status_pkg.sv ====
// types of the buffer status block
package fifo_status_pkg;
    typedef enum logic [2:0] {
        MODE_BYPASS = 3'h0,
        MODE_FIFO   = 3'h1,
        MODE_CONT   = 3'h6
    } buffer_mode_t;

    typedef enum logic [4:0] {
        SENS_ACCEL = 5'h02,
        SENS_TEMP  = 5'h03,
        SENS_TIME  = 5'h04
    } sensor_code_t;

    typedef logic [55:0] buf_word_t;
endpackage

// ==== rtl/fifo_status.sv ====
// sensor buffer with fill status, batch counter, tagging and register port
// Function
// - batch counter advances once per accelerometer data ready event, even when the sample is dropped because the buffer is full
// - writing the clear bit zeroes the batch counter; the bit reads back zero
// - 11-bit threshold: bits 10..8 in high register, bits 7..0 in low
// - batch flag sets when the counter reaches the threshold
// - reading the second status register clears the batch flag
// - 10-bit unread word count split over both status registers
// - watermark flag high while stored words reach the watermark
// - overrun flag sets on overwrite, clears when a word is read
// - sticky overrun flag clears only on second status register read
// - full flag high when next write fills the buffer or overruns
// - four flags routable to two interrupt outputs by enable bits
// - status follows every buffer write and read
// - with block update, second status is the pair captured at first read
// - tag holds sensor code, time slot counter and parity
// - sensor codes for accelerometer, temperature and timestamp words
// - tag parity makes the count of ones even
// - six output registers show the current word's data bytes
// - bypass mode empties the buffer and keeps it empty
// - timestamp decimation off, by 1, by 8 or by 32
// - temperature batching off or on at its own tick
// - words are written on accelerometer data ready; queued temperature and timestamp words go in the cycles after it
`timescale 1ns/10ps
`include "fifo_status_map.svh"

module fifo_status #(
    parameter int DEPTH = 512
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        accel_drdy,
    input  wire logic [15:0] accel_x,
    input  wire logic [15:0] accel_y,
    input  wire logic [15:0] accel_z,
    input  wire logic        temp_tick,
    input  wire logic [15:0] temp_value,
    input  wire logic [31:0] time_stamp,
    output logic             irq_out_a,
    output logic             irq_out_b
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] NEAR_CNT = CW'(DEPTH - 1);

    function automatic logic [7:0] mk_tag(input logic [4:0] code,
                                          input logic [1:0] slot);
        mk_tag = {code, slot, ^{code, slot}};
    endfunction

    function automatic logic [7:0] byte_of(input fifo_status_pkg::buf_word_t w,
                                           input logic [2:0] n);
        byte_of = w[8*n +: 8];
    endfunction

    // bus side
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [7:0]  idx;
    logic        rd_acc;
    logic        wr_acc;
    logic [7:0]  wbyte;

    // control registers
    logic [8:0]  wtm_q;
    logic [3:0]  rate_q;
    logic [2:0]  mode_q;
    logic [1:0]  trate_q;
    logic [1:0]  tdec_q;
    logic [10:0] thr_q;
    logic [3:0]  en1_q;
    logic [3:0]  en2_q;
    logic        bdu_q;

    // buffer state
    fifo_status_pkg::buf_word_t mem_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [CW-1:0] cnt_q;
    logic [10:0]   bcnt_q;
    logic [1:0]    slot_q;
    logic [4:0]    dcnt_q;
    logic          pend_t_q;
    logic          pend_ts_q;
    logic          tdue_q;
    logic          ovr_q;
    logic          ovr_sticky_q;
    logic          bflag_q;
    logic [7:0]    snap_q;
    logic          irq_a_q;
    logic          irq_b_q;

    // derived
    logic          bypass;
    logic          acc_evt;
    logic          ts_due;
    logic          wr_go;
    logic          do_wr;
    logic          ovw;
    logic          pop;
    logic          bclr;
    logic          bhit;
    logic          wm_flag;
    logic          full_flag;
    logic [7:0]    st_hi;
    logic [3:0]    flags;
    logic [1:0]    slot_d;
    fifo_status_pkg::buf_word_t wword;
    fifo_status_pkg::buf_word_t cur;
    logic [7:0]    rmux;
    logic [9:0]    level;

    assign idx    = address[9:2];
    assign rd_acc = read && wait_q;
    assign wr_acc = write && !read && wait_q && byteenable[0];
    assign wbyte  = writedata[7:0];
    assign bypass = mode_q == fifo_status_pkg::MODE_BYPASS;
    assign cur    = mem_q[rp_q];

    // one wait cycle per access
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((read || write) && wait_q);
        end
    end

    // control register writes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wtm_q   <= 9'h000;
            rate_q  <= 4'h0;
            mode_q  <= 3'h0;
            trate_q <= 2'h0;
            tdec_q  <= 2'h0;
            thr_q   <= `RST_THRESH;
            en1_q   <= 4'h0;
            en2_q   <= 4'h0;
            bdu_q   <= 1'b0;
        end else if (wr_acc) begin
            unique case (idx)
                `IDX_WTM_LO:     wtm_q[7:0] <= wbyte;
                `IDX_WTM_HI:     wtm_q[8] <= wbyte[0];
                `IDX_RATE:       rate_q <= wbyte[`RATE_FLD];
                `IDX_MODE_CTRL: begin
                    mode_q  <= wbyte[`MODE_FLD];
                    trate_q <= wbyte[`TRATE_FLD];
                    tdec_q  <= wbyte[`TDEC_FLD];
                end
                `IDX_BCNT_HI:    thr_q[10:8] <= wbyte[`BCNT_TH_HI_FLD];
                `IDX_BCNT_LO:    thr_q[7:0] <= wbyte;
                `IDX_IRQ1_ROUTE: en1_q <= wbyte[`ROUTE_FLD];
                `IDX_IRQ2_ROUTE: en2_q <= wbyte[`ROUTE_FLD];
                `IDX_BDU_CTRL:   bdu_q <= wbyte[`BDU_BIT];
                default: ;
            endcase
        end
    end

    // write scheduling
    assign acc_evt = accel_drdy && !bypass && rate_q != `RATE_OFF;
    assign wr_go   = !bypass && (acc_evt || pend_t_q || pend_ts_q);
    assign slot_d  = slot_q + 2'h1;

    always_comb begin
        unique case (tdec_q)
            `TDEC_OFF:  ts_due = 1'b0;
            `TDEC_DIV1: ts_due = 1'b1;
            `TDEC_DIV8: ts_due = dcnt_q[2:0] == 3'h0;
            default:    ts_due = dcnt_q == 5'h00;
        endcase
    end

    always_comb begin
        if (acc_evt) begin
            wword = {mk_tag(fifo_status_pkg::SENS_ACCEL, slot_d),
                     accel_z, accel_y, accel_x};
        end else if (pend_t_q) begin
            wword = {mk_tag(fifo_status_pkg::SENS_TEMP, slot_q),
                     32'h0000_0000, temp_value};
        end else begin
            wword = {mk_tag(fifo_status_pkg::SENS_TIME, slot_q),
                     4'h0, rate_q, 8'h00, time_stamp};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst || bypass) begin
            pend_t_q  <= 1'b0;
            pend_ts_q <= 1'b0;
        end else begin
            if (acc_evt) begin
                pend_t_q  <= trate_q == `TRATE_ON && (tdue_q || temp_tick);
                pend_ts_q <= ts_due;
            end else if (pend_t_q) begin
                pend_t_q <= 1'b0;
            end else begin
                pend_ts_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tdue_q <= 1'b0;
        end else if (acc_evt && trate_q == `TRATE_ON) begin
            tdue_q <= 1'b0;
        end else if (temp_tick) begin
            tdue_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            slot_q <= 2'h0;
            dcnt_q <= 5'h00;
        end else if (acc_evt) begin
            slot_q <= slot_d;
            dcnt_q <= dcnt_q + 5'h01;
        end
    end

    // pointers and fill level
    assign pop = rd_acc && idx == `IDX_OUT_ZH && cnt_q != '0;
    assign ovw = wr_go && cnt_q == FULL_CNT && !pop
                 && mode_q != fifo_status_pkg::MODE_FIFO;
    assign do_wr = wr_go && (cnt_q != FULL_CNT || pop || ovw);

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_q[wp_q] <= wword;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst || bypass) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wp_q <= wp_q + PW'(1);
            end
            if (pop || ovw) begin
                rp_q <= rp_q + PW'(1);
            end
            if (do_wr && !pop && !ovw) begin
                cnt_q <= cnt_q + CW'(1);
            end else if (pop && !do_wr) begin
                cnt_q <= cnt_q - CW'(1);
            end
        end
    end

    // flags
    assign wm_flag   = cnt_q >= {1'b0, wtm_q};
    assign full_flag = cnt_q >= NEAR_CNT;
    assign level     = 10'(cnt_q);

    always_ff @(posedge clk) begin
        if (!nrst || bypass) begin
            ovr_q <= 1'b0;
        end else if (ovw) begin
            ovr_q <= 1'b1;
        end else if (pop) begin
            ovr_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ovr_sticky_q <= 1'b0;
        end else if (ovw) begin
            ovr_sticky_q <= 1'b1;
        end else if (rd_acc && idx == `IDX_STATUS_HI) begin
            ovr_sticky_q <= 1'b0;
        end
    end

    // batch counter
    assign bclr = wr_acc && idx == `IDX_BCNT_HI && wbyte[`BCNT_CLR_BIT];
    assign bhit = acc_evt && !bclr && bcnt_q + 11'h001 == thr_q;

    always_ff @(posedge clk) begin
        if (!nrst || bclr) begin
            bcnt_q <= 11'h000;
        end else if (bhit) begin
            bcnt_q <= 11'h000;
        end else if (acc_evt) begin
            bcnt_q <= bcnt_q + 11'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bflag_q <= 1'b0;
        end else if (bhit) begin
            bflag_q <= 1'b1;
        end else if (rd_acc && idx == `IDX_STATUS_HI) begin
            bflag_q <= 1'b0;
        end
    end

    assign st_hi = {wm_flag, ovr_q, full_flag, bflag_q,
                    ovr_sticky_q, 1'b0, level[9:8]};
    assign flags = {bflag_q, full_flag, ovr_q, wm_flag};

    // coherent pair capture
    always_ff @(posedge clk) begin
        if (!nrst) begin
            snap_q <= 8'h00;
        end else if (rd_acc && idx == `IDX_STATUS_LO) begin
            snap_q <= st_hi;
        end
    end

    // interrupt routing
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
        end else begin
            irq_a_q <= |(flags & en1_q);
            irq_b_q <= |(flags & en2_q);
        end
    end

    // read mux
    always_comb begin
        rmux = 8'h00;
        unique case (idx)
            `IDX_WTM_LO:     rmux = wtm_q[7:0];
            `IDX_WTM_HI:     rmux = {7'h00, wtm_q[8]};
            `IDX_RATE:       rmux = {4'h0, rate_q};
            `IDX_MODE_CTRL:  rmux = {tdec_q, trate_q, 1'b0, mode_q};
            `IDX_BCNT_HI:    rmux = {5'h00, thr_q[10:8]};
            `IDX_BCNT_LO:    rmux = thr_q[7:0];
            `IDX_IRQ1_ROUTE: rmux = {1'b0, en1_q, 3'h0};
            `IDX_IRQ2_ROUTE: rmux = {1'b0, en2_q, 3'h0};
            `IDX_BDU_CTRL:   rmux = {1'b0, bdu_q, 6'h00};
            `IDX_STATUS_LO:  rmux = level[7:0];
            `IDX_STATUS_HI:  rmux = bdu_q ? snap_q : st_hi;
            `IDX_TAG:        rmux = cnt_q != '0 ? cur[55:48] : 8'h00;
            default: begin
                if (idx >= `IDX_OUT_XL && idx <= `IDX_OUT_ZH && cnt_q != '0) begin
                    rmux = byte_of(cur, 3'(idx - `IDX_OUT_XL));
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_acc) begin
            rdata_q <= {24'h00_0000, rmux};
        end
    end

    assign readdata    = rdata_q;
    assign waitrequest = wait_q;
    assign irq_out_a   = irq_a_q;
    assign irq_out_b   = irq_b_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_bypass_empty;
        bypass |=> cnt_q == '0;
    endproperty
    a_bypass_empty: assert property (p_bypass_empty)
        else $error("buffer not empty in bypass");

    property p_batch_clear;
        bclr |=> bcnt_q == 11'h000 && !$past(bhit);
    endproperty
    a_batch_clear: assert property (p_batch_clear)
        else $error("batch counter not cleared");

    property p_batch_step;
        acc_evt && !bclr && !bhit |=> bcnt_q == $past(bcnt_q) + 11'h001;
    endproperty
    a_batch_step: assert property (p_batch_step)
        else $error("batch counter did not advance");

    property p_batch_flag_set;
        acc_evt && !bclr && bcnt_q + 11'h001 == thr_q |=> bflag_q;
    endproperty
    a_batch_flag_set: assert property (p_batch_flag_set)
        else $error("batch flag missed threshold");

    property p_batch_flag_rd;
        rd_acc && idx == `IDX_STATUS_HI && !bhit |=> !bflag_q;
    endproperty
    a_batch_flag_rd: assert property (p_batch_flag_rd)
        else $error("batch flag kept after read");

    property p_ovr_set;
        ovw |=> ovr_q && ovr_sticky_q && cnt_q == FULL_CNT;
    endproperty
    a_ovr_set: assert property (p_ovr_set)
        else $error("overrun flags not raised");

    property p_ovr_clr;
        pop && !ovw && !bypass |=> !ovr_q;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr)
        else $error("overrun flag kept after pop");

    property p_count_up;
        do_wr && !pop && !ovw && !bypass |=> cnt_q == $past(cnt_q) + CW'(1);
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("count not raised by write");

    property p_tag_parity;
        rd_acc && idx == `IDX_TAG |=> ^rdata_q[7:0] == 1'b0;
    endproperty
    a_tag_parity: assert property (p_tag_parity)
        else $error("tag parity odd");

    property p_answer;
        (read || write) && wait_q |=> !waitrequest ##1 waitrequest;
    endproperty
    a_answer: assert property (p_answer)
        else $error("bus answer timing broken");

    c_overwrite: cover property (ovw);
    c_batch_hit: cover property (bhit);
    c_pop_full: cover property (pop && cnt_q == FULL_CNT);
    c_three_words: cover property (acc_evt ##1 pend_t_q ##1 pend_ts_q);
endmodule

// ==== tb/host_port_model.sv ====
// host model: register master on the avalon port of the buffer status block
`timescale 1ns/10ps
`include "fifo_status_map.svh"

module host_port_model (
    input  wire logic        clk,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest,
    output logic [9:0]       address,
    output logic             read,
    output logic             write,
    output logic [31:0]      writedata,
    output logic [3:0]       byteenable
);
    initial begin
        address    = 10'h000;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h00000000;
        byteenable = 4'hF;
    end

    // one bus cycle, held until waitrequest sampled low
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                        output logic [7:0] rd);
        @(posedge clk);
        address   <= {idx, 2'b00};
        writedata <= {24'h000000, wd};
        read      <= ~wr;
        write     <= wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rd = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    // low half first, so a held pair stays coherent
    task automatic rd_status(output logic [7:0] lo, output logic [7:0] hi);
        xfer(`IDX_STATUS_LO, 1'b0, 8'h00, lo);
        xfer(`IDX_STATUS_HI, 1'b0, 8'h00, hi);
    endtask

    // even count of ones marks a sound tag
    function automatic logic tag_ok(input logic [7:0] t);
        return ~^t;
    endfunction
endmodule

// ==== tb/tb_fifo_status.sv ====
// testbench of the buffer status block
`timescale 1ns/10ps
`include "fifo_status_map.svh"

module tb_fifo_status;
    logic        clk;
    logic        nrst;
    logic [9:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        accel_drdy;
    logic [15:0] accel_x;
    logic [15:0] accel_y;
    logic [15:0] accel_z;
    logic        temp_tick;
    logic [15:0] temp_value;
    logic [31:0] time_stamp;
    logic        irq_out_a;
    logic        irq_out_b;
    int          fails;
    int          checks;

    fifo_status #(.DEPTH(8)) u_fifo_status (
        .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .accel_drdy(accel_drdy), .accel_x(accel_x),
        .accel_y(accel_y), .accel_z(accel_z), .temp_tick(temp_tick),
        .temp_value(temp_value), .time_stamp(time_stamp),
        .irq_out_a(irq_out_a), .irq_out_b(irq_out_b)
    );

    host_port_model u_host_port_model (
        .clk(clk), .readdata(readdata), .waitrequest(waitrequest), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [7:0] d;
        u_host_port_model.xfer(idx, 1'b1, v, d);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] v);
        u_host_port_model.xfer(idx, 1'b0, 8'h00, v);
    endtask

    task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        rd(idx, v);
        check(v, exp);
    endtask

    // one accelerometer sample, spaced per the sample link order
    task automatic push(input logic [15:0] base);
        @(posedge clk);
        accel_drdy <= 1'b1;
        accel_x    <= base;
        accel_y    <= base + 16'h0100;
        accel_z    <= base + 16'h0200;
        @(posedge clk);
        accel_drdy <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic push_n(input int n, input logic [15:0] base);
        for (int i = 0; i < n; i++) begin
            push(base + 16'(i));
        end
    endtask

    task automatic rd_word(output logic [7:0] t, output logic [47:0] d);
        logic [7:0] b;
        rd(`IDX_TAG, t);
        for (int i = 0; i < 6; i++) begin
            rd(`IDX_OUT_XL + 8'(i), b);
            d[8*i +: 8] = b;
        end
    endtask

    // bypass first to empty, then the new mode
    task automatic restart(input logic [7:0] mode);
        wr(`IDX_MODE_CTRL, 8'h00);
        chk_rd(`IDX_STATUS_LO, 8'h00);
        wr(`IDX_MODE_CTRL, mode);
    endtask

    task automatic test_reset_regs();
        chk_rd(`IDX_MODE_CTRL, 8'h00);
        chk_rd(`IDX_BCNT_HI, 8'h00);
        chk_rd(`IDX_BCNT_LO, 8'h00);
        chk_rd(`IDX_STATUS_LO, 8'h00);
        chk_rd(`IDX_STATUS_HI, 8'h80);
        chk_rd(`IDX_TAG, 8'h00);
        wr(8'h60, 8'h55);
        chk_rd(8'h60, 8'h00);
        wr(`IDX_MODE_CTRL, 8'hFF);
        chk_rd(`IDX_MODE_CTRL, 8'hF7);
        wr(`IDX_MODE_CTRL, 8'h00);
        wr(`IDX_RATE, 8'h0A);
        push(16'h0F00);
        chk_rd(`IDX_STATUS_LO, 8'h00);
        $display("test reset_regs done");
    endtask

    task automatic test_fill_flags();
        logic [7:0]  t;
        logic [47:0] d;
        wr(`IDX_WTM_LO, 8'h03);
        restart(8'h06);
        push_n(7, 16'h1000);
        chk_rd(`IDX_STATUS_LO, 8'h07);
        chk_rd(`IDX_STATUS_HI, 8'hA0);
        push_n(2, 16'h1007);
        chk_rd(`IDX_STATUS_LO, 8'h08);
        chk_rd(`IDX_STATUS_HI, 8'hE8);
        chk_rd(`IDX_STATUS_HI, 8'hE0);
        rd_word(t, d);
        check(d, {16'h1201, 16'h1101, 16'h1001});
        check(t[7:3], 5'h02);
        check(u_host_port_model.tag_ok(t), 1'b1);
        chk_rd(`IDX_STATUS_LO, 8'h07);
        chk_rd(`IDX_STATUS_HI, 8'hA0);
        restart(8'h01);
        push_n(9, 16'h3000);
        chk_rd(`IDX_STATUS_LO, 8'h08);
        chk_rd(`IDX_STATUS_HI, 8'hA0);
        rd_word(t, d);
        check(d, {16'h3200, 16'h3100, 16'h3000});
        $display("test fill_flags done");
    endtask

    task automatic test_irq();
        restart(8'h06);
        push_n(3, 16'h4000);
        wr(`IDX_IRQ1_ROUTE, 8'h08);
        wr(`IDX_IRQ2_ROUTE, 8'h20);
        repeat (3) @(posedge clk);
        check(irq_out_a, 1'b1);
        check(irq_out_b, 1'b0);
        wr(`IDX_IRQ1_ROUTE, 8'h00);
        push_n(4, 16'h4003);
        repeat (3) @(posedge clk);
        check(irq_out_a, 1'b0);
        check(irq_out_b, 1'b1);
        wr(`IDX_IRQ2_ROUTE, 8'h00);
        $display("test irq done");
    endtask

    task automatic test_batch_counter();
        logic [7:0] v;
        restart(8'h06);
        wr(`IDX_BCNT_HI, 8'h47);
        chk_rd(`IDX_BCNT_HI, 8'h07);
        wr(`IDX_BCNT_LO, 8'hFF);
        chk_rd(`IDX_BCNT_LO, 8'hFF);
        wr(`IDX_BCNT_HI, 8'h40);
        wr(`IDX_BCNT_LO, 8'h03);
        rd(`IDX_STATUS_HI, v);
        push_n(2, 16'h5000);
        wr(`IDX_BCNT_HI, 8'h40);
        push_n(2, 16'h5002);
        rd(`IDX_STATUS_HI, v);
        check(v & 8'h10, 8'h00);
        push(16'h5004);
        rd(`IDX_STATUS_HI, v);
        check(v & 8'h10, 8'h10);
        rd(`IDX_STATUS_HI, v);
        check(v & 8'h10, 8'h00);
        $display("test batch_counter done");
    endtask

    task automatic test_block_update();
        logic [7:0] lo;
        logic [7:0] hi;
        restart(8'h06);
        wr(`IDX_BDU_CTRL, 8'h40);
        push_n(2, 16'h6000);
        u_host_port_model.rd_status(lo, hi);
        push(16'h6002);
        chk_rd(`IDX_STATUS_HI, 8'h00);
        u_host_port_model.rd_status(lo, hi);
        check({lo, hi}, 16'h0380);
        wr(`IDX_BDU_CTRL, 8'h00);
        $display("test block_update done");
    endtask

    task automatic test_tags();
        logic [7:0]  t0;
        logic [7:0]  t;
        logic [47:0] d;
        restart(8'h76);
        @(posedge clk);
        temp_value <= 16'h5A3C;
        time_stamp <= 32'h87654321;
        temp_tick  <= 1'b1;
        @(posedge clk);
        temp_tick <= 1'b0;
        push(16'h2000);
        chk_rd(`IDX_STATUS_LO, 8'h03);
        rd_word(t0, d);
        check({t0[7:3], d}, {5'h02, 16'h2200, 16'h2100, 16'h2000});
        rd_word(t, d);
        check({t[7:3], d}, {5'h03, 32'h00000000, 16'h5A3C});
        check(t[2:1], t0[2:1]);
        check(u_host_port_model.tag_ok(t), 1'b1);
        rd_word(t, d);
        check({t[7:3], d}, {5'h04, 8'h0A, 8'h00, 32'h87654321});
        check(u_host_port_model.tag_ok(t), 1'b1);
        push(16'h2010);
        chk_rd(`IDX_STATUS_LO, 8'h02);
        rd_word(t, d);
        check(t[2:1], 2'(t0[2:1] + 2'h1));
        $display("test tags done");
    endtask

    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #800000;
        fails++;
        wrap_up();
    end

    initial begin
        fails      = 0;
        checks     = 0;
        nrst       = 1'b0;
        accel_drdy = 1'b0;
        accel_x    = 16'h0000;
        accel_y    = 16'h0000;
        accel_z    = 16'h0000;
        temp_tick  = 1'b0;
        temp_value = 16'h0000;
        time_stamp = 32'h00000000;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        test_reset_regs();
        test_fill_flags();
        test_irq();
        test_batch_counter();
        test_block_update();
        test_tags();
        wrap_up();
    end
endmodule
